// [verilog/fpm_mul_top.sv]
// Six-stage pipelined fp8 multiplier, truncating and saturating
`timescale 1ns/1ps
module fpm_mul_top (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Operand a pins
   input  wire fpm_pkg::fpm_fp8_t operand_a_pins,
   // Operand b on the two-way pins, used as inputs only
   input  wire fpm_pkg::fpm_fp8_t operand_b_in,
   output      fpm_pkg::fpm_fp8_t operand_b_out,
   output      logic              operand_b_oe,
   // Product
   output      fpm_pkg::fpm_fp8_t product_pins
);
   import fpm_pkg::*;

   // ------------------------------------------------------------
   // Stage 1: operand capture
   // ------------------------------------------------------------
   // Host is clocked with us, so no synchroniser: it would add latency
   fpm_fp8_t s1_a_reg;
   fpm_fp8_t s1_b_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s1_a_reg <= RST_BYTE;
         s1_b_reg <= RST_BYTE;
      end else begin
         s1_a_reg <= operand_a_pins;
         s1_b_reg <= operand_b_in;
      end
   end

   // Two-way pins never driven
   always_ff @(posedge clk) begin
      operand_b_out <= RST_BYTE;
      operand_b_oe  <= 1'b0;
   end

   // ------------------------------------------------------------
   // Stage 2: unpack and multiply significands
   // ------------------------------------------------------------
   fpm_fields_if fa ();
   fpm_fields_if fb ();

   fpm_unpack u_unpack_a (
      .operand (s1_a_reg),
      .fields  (fa.src)
   );

   fpm_unpack u_unpack_b (
      .operand (s1_b_reg),
      .fields  (fb.src)
   );

   logic       s2_sign_reg;
   logic [4:0] s2_esum_reg;
   logic [7:0] s2_prod_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s2_sign_reg <= 1'b0;
         s2_esum_reg <= 5'h00;
         s2_prod_reg <= 8'h00;
      end else begin
         s2_sign_reg <= fa.sign ^ fb.sign;
         s2_esum_reg <= {1'b0, fa.exp_eff} + {1'b0, fb.exp_eff};
         s2_prod_reg <= {4'h0, fa.sig} * {4'h0, fb.sig};
      end
   end

   // ------------------------------------------------------------
   // Stage 3: leading one search
   // ------------------------------------------------------------
   function automatic logic [2:0] lead_one(input logic [7:0] p);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (p[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   logic       s3_sign_reg;
   logic [4:0] s3_esum_reg;
   logic [7:0] s3_prod_reg;
   logic [2:0] s3_lead_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s3_sign_reg <= 1'b0;
         s3_esum_reg <= 5'h00;
         s3_prod_reg <= 8'h00;
         s3_lead_reg <= 3'h0;
      end else begin
         s3_sign_reg <= s2_sign_reg;
         s3_esum_reg <= s2_esum_reg;
         s3_prod_reg <= s2_prod_reg;
         s3_lead_reg <= lead_one(s2_prod_reg);
      end
   end

   // ------------------------------------------------------------
   // Stage 4: normal and subnormal candidates
   // ------------------------------------------------------------
   logic signed [6:0] exp_norm;
   logic signed [5:0] sub_shift;
   logic        [7:0] norm_val;
   logic        [7:0] sub_val;

   always_comb begin
      exp_norm  = $signed({2'b00, s3_esum_reg} + {4'h0, s3_lead_reg} - NORM_OFFSET);
      sub_shift = $signed({1'b0, s3_esum_reg} - SUB_OFFSET);
      // Shifts drop low bits: truncation toward zero
      if (s3_lead_reg >= HIDDEN_POS) begin
         norm_val = s3_prod_reg >> (s3_lead_reg - HIDDEN_POS);
      end else begin
         norm_val = s3_prod_reg << (HIDDEN_POS - s3_lead_reg);
      end
      if (sub_shift >= 0) begin
         sub_val = s3_prod_reg << sub_shift;
      end else begin
         sub_val = s3_prod_reg >> (-sub_shift);
      end
   end

   logic              s4_sign_reg;
   logic              s4_zero_reg;
   logic signed [6:0] s4_exp_reg;
   logic        [2:0] s4_norm_reg;
   logic        [2:0] s4_sub_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s4_sign_reg <= 1'b0;
         s4_zero_reg <= 1'b1;
         s4_exp_reg  <= 7'sh00;
         s4_norm_reg <= 3'h0;
         s4_sub_reg  <= 3'h0;
      end else begin
         s4_sign_reg <= s3_sign_reg;
         s4_zero_reg <= (s3_prod_reg == 8'h00);
         s4_exp_reg  <= exp_norm;
         s4_norm_reg <= norm_val[2:0];
         s4_sub_reg  <= sub_val[2:0];
      end
   end

   // ------------------------------------------------------------
   // Stage 5: select, saturate, pack
   // ------------------------------------------------------------
   fpm_fp8_t s5_res_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s5_res_reg <= RST_BYTE;
      end else if (s4_zero_reg) begin
         s5_res_reg <= {s4_sign_reg, 7'h00};
      end else if (s4_exp_reg > $signed({3'b000, EXP_TOP})) begin
         // No infinity code exists, so clamp to the top finite value
         s5_res_reg <= {s4_sign_reg, MAG_MAX};
      end else if (s4_exp_reg >= $signed({3'b000, EXP_SUB_EFF})) begin
         s5_res_reg <= {s4_sign_reg, s4_exp_reg[3:0], s4_norm_reg};
      end else begin
         s5_res_reg <= {s4_sign_reg, EXP_SUB, s4_sub_reg};
      end
   end

   // ------------------------------------------------------------
   // Stage 6: output register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         product_pins <= RST_BYTE;
      end else begin
         product_pins <= s5_res_reg;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Exact values in units of 2^-20, independent of the datapath
   function automatic logic [39:0] code_val(input logic [6:0] c);
      logic [3:0] e;
      logic [3:0] m;
      e = (c[6:3] == EXP_SUB) ? EXP_SUB_EFF : c[6:3];
      m = {(c[6:3] != EXP_SUB), c[2:0]};
      // Shift needs five bits: exponent 15 plus ten overflows a nibble
      return 40'(m) << ({1'b0, e} + 5'h0A);
   endfunction

   function automatic logic [39:0] prod_val(input logic [7:0] a, input logic [7:0] b);
      logic [3:0] ea;
      logic [3:0] eb;
      logic [7:0] p;
      ea = (a[6:3] == EXP_SUB) ? EXP_SUB_EFF : a[6:3];
      eb = (b[6:3] == EXP_SUB) ? EXP_SUB_EFF : b[6:3];
      p  = {4'h0, (a[6:3] != EXP_SUB), a[2:0]} * {4'h0, (b[6:3] != EXP_SUB), b[2:0]};
      return 40'(p) << ({1'b0, ea} + {1'b0, eb});
   endfunction

   function automatic logic [6:0] ref_mag(input logic [7:0] a, input logic [7:0] b);
      logic [39:0] q;
      logic [6:0]  best;
      q    = prod_val(a, b);
      best = 7'h00;
      for (int i = 0; i < 128; i++) begin
         if (code_val(7'(i)) <= q) begin
            best = 7'(i);
         end
      end
      return best;
   endfunction

   // Pipeline is meaningful only once filled after reset
   logic [2:0] fill_reg;
   logic       fill_done;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fill_reg <= RST_FILL;
      end else if (fill_reg != 3'(PIPE_DEPTH)) begin
         fill_reg <= fill_reg + 3'h1;
      end
   end

   assign fill_done = (fill_reg == 3'(PIPE_DEPTH));

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence ones_pair;
      operand_a_pins == 8'h38 && operand_b_in == 8'h38;
   endsequence

   sequence one_two_pair;
      operand_a_pins == 8'h38 && operand_b_in == 8'h40;
   endsequence

   chk_product_value: assert property (fill_done |->
      product_pins[6:0] == ref_mag($past(operand_a_pins, 6), $past(operand_b_in, 6)))
      else $error("product magnitude differs from reference");

   chk_latency_six: assert property (ones_pair |-> ##6 product_pins == 8'h38)
      else $error("product not seen six cycles after sampling");

   chk_field_layout: assert property (
      (operand_a_pins[2:0] == 3'h0 && operand_b_in[2:0] == 3'h0 &&
       operand_a_pins[6:3] != 4'h0 && operand_b_in[6:3] != 4'h0 &&
       ({1'b0, operand_a_pins[6:3]} + {1'b0, operand_b_in[6:3]}) inside {[8:22]})
      |-> ##6 (product_pins[2:0] == 3'h0 && {1'b0, product_pins[6:3]} ==
               5'({1'b0, $past(operand_a_pins[6:3], 6)} +
                  {1'b0, $past(operand_b_in[6:3], 6)} - 5'h07)))
      else $error("exponent field not at bits 6 to 3");

   chk_trunc_down: assert property (fill_done |->
      code_val(product_pins[6:0]) <= prod_val($past(operand_a_pins, 6), $past(operand_b_in, 6)))
      else $error("product rounded up in magnitude");

   chk_saturate_top: assert property (
      (fill_done && prod_val($past(operand_a_pins, 6), $past(operand_b_in, 6)) >=
       code_val(MAG_MAX)) |-> product_pins[6:0] == MAG_MAX)
      else $error("overflow did not saturate");

   chk_max_480: assert property (
      (operand_a_pins[6:0] == MAG_MAX && operand_b_in[6:0] == 7'h38) |->
      ##6 (product_pins[6:0] == MAG_MAX &&
           code_val(product_pins[6:0]) == (40'(MAX_FINITE) << FRAC_UNITS)))
      else $error("top finite code not 480");

   chk_subnormal_out: assert property (
      (fill_done && prod_val($past(operand_a_pins, 6), $past(operand_b_in, 6)) <
       code_val(7'h08)) |-> product_pins[6:3] == EXP_SUB)
      else $error("small product not subnormal");

   chk_unit_ident: assert property (
      (operand_a_pins[6:0] == 7'h38 && operand_b_in[6:3] != EXP_SUB) |->
      ##6 product_pins[6:0] == $past(operand_b_in[6:0], 6))
      else $error("one times b did not give b");

   chk_sign_xor: assert property (fill_done |->
      product_pins[7] == ($past(operand_a_pins[7], 6) ^ $past(operand_b_in[7], 6)))
      else $error("product sign wrong");

   chk_back_to_back: assert property (ones_pair ##1 one_two_pair |->
      ##5 product_pins == 8'h38 ##1 product_pins == 8'h40)
      else $error("back to back pairs not both produced");

endmodule

// [verilog/fpm_pkg.sv]
// Package with format constants and pipeline figures for the fp8 multiplier
//
// Functional notes
// - Output the floating point product of operands a and b on product pins.
// - Result appears exactly six clocks after its operand pair is sampled.
// - Format: sign bit 7, biased exponent bits 6..3, mantissa bits 2..0.
// - Inexact products truncate toward zero, never grow in magnitude.
// - Overflowing products saturate to the largest finite magnitude, sign kept.
// - No infinity or NaN; exponent field 15 is finite, up to 480.
// - Exponent field zero is subnormal, exponent minus six, no hidden one.
// - Normal value is (1 + mantissa/8) times two to (exponent - 7).
// - Every magnitude also exists negative through the sign bit.
package fpm_pkg;

   typedef logic [7:0] fpm_fp8_t;

   // --------------------------------------------------------------
   // Field layout
   // --------------------------------------------------------------
   localparam int SIGN_BIT = 7;
   localparam int EXP_HI   = 6;
   localparam int EXP_LO   = 3;
   localparam int MAN_HI   = 2;
   localparam int MAN_LO   = 0;

   // --------------------------------------------------------------
   // Arithmetic constants
   // --------------------------------------------------------------
   localparam logic [3:0] EXP_SUB      = 4'h0;
   localparam logic [3:0] EXP_SUB_EFF  = 4'h1;
   localparam logic [3:0] EXP_TOP      = 4'hF;
   localparam logic [6:0] MAG_MAX      = 7'h7F;
   localparam logic [2:0] HIDDEN_POS   = 3'h3;
   localparam logic [6:0] NORM_OFFSET  = 7'h0D;
   localparam logic [5:0] SUB_OFFSET   = 6'h0B;
   localparam int         MAX_FINITE   = 480;
   localparam int         FRAC_UNITS   = 20;

   // --------------------------------------------------------------
   // Pipeline and reset values
   // --------------------------------------------------------------
   localparam int          PIPE_DEPTH  = 6;
   localparam logic [7:0]  RST_BYTE    = 8'h00;
   localparam logic [2:0]  RST_FILL    = 3'h0;

endpackage

// [verilog/fpm_fields_if.sv]
// Interface carrying one unpacked operand between unpacker and datapath
`timescale 1ns/1ps
interface fpm_fields_if;
   logic       sign;
   logic [3:0] exp_eff;
   logic [3:0] sig;

   modport src (output sign, output exp_eff, output sig);
   modport dst (input sign, input exp_eff, input sig);
endinterface

// [verilog/fpm_unpack.sv]
// Unpacker from an fp8 byte to sign, effective exponent and significand
`timescale 1ns/1ps
module fpm_unpack (
   // Packed operand
   input  wire fpm_pkg::fpm_fp8_t operand,
   // Unpacked fields
   fpm_fields_if.src              fields
);
   import fpm_pkg::*;

   logic is_sub;

   assign is_sub         = (operand[EXP_HI:EXP_LO] == EXP_SUB);
   assign fields.sign    = operand[SIGN_BIT];
   // Subnormal shares exponent of field 1 but drops the hidden one
   assign fields.exp_eff = is_sub ? EXP_SUB_EFF : operand[EXP_HI:EXP_LO];
   assign fields.sig     = {~is_sub, operand[MAN_HI:MAN_LO]};

endmodule

// [test/fpm_host_model.sv]
// Host model that presents operand pairs to the fp8 multiplier pins
`timescale 1ns/1ps
module fpm_host_model (
   // Clock
   input  wire logic              clk,
   // Operand pins
   output      fpm_pkg::fpm_fp8_t operand_a_pins,
   output      fpm_pkg::fpm_fp8_t operand_b_in,
   // Two-way pins, device side
   input  wire fpm_pkg::fpm_fp8_t operand_b_out,
   input  wire logic              operand_b_oe
);
   import fpm_pkg::*;

   fpm_fp8_t drv_a_reg;
   fpm_fp8_t drv_b_reg;

   initial begin
      drv_a_reg = 8'h00;
      drv_b_reg = 8'h00;
   end

   // --------------------------------------------------------------
   // Pin drive
   // --------------------------------------------------------------
   assign operand_a_pins = drv_a_reg;
   // Wire level picked by the device enable: device drive while enabled, host drive only while device is off
   assign operand_b_in = operand_b_oe ? operand_b_out : drv_b_reg;

   // One pair each cycle, changed just after the edge, held through the next
   task automatic put(input fpm_fp8_t a, input fpm_fp8_t b);
      @(posedge clk);
      #1;
      drv_a_reg = a;
      drv_b_reg = b;
   endtask
endmodule

// [test/fpm_mul_top_tb_top.sv]
// Self-checking bench for the fp8 pipelined multiplier
`timescale 1ns/1ps
module fpm_mul_top_tb_top;
   import fpm_pkg::*;

   logic     clk;
   logic     reset_n;
   fpm_fp8_t a_pins;
   fpm_fp8_t b_wire;
   fpm_fp8_t b_out;
   logic     b_oe;
   fpm_fp8_t product;
   int       n_fail;
   int       n_checks;
   fpm_fp8_t qa[$];
   fpm_fp8_t qb[$];
   fpm_fp8_t qe[$];

   initial clk = 1'b0;
   always #4 clk = ~clk;

   fpm_mul_top fpm_mul_top_inst (
      .clk(clk), .reset_n(reset_n), .operand_a_pins(a_pins),
      .operand_b_in(b_wire), .operand_b_out(b_out),
      .operand_b_oe(b_oe), .product_pins(product));

   fpm_host_model fpm_host_model_inst (
      .clk(clk), .operand_a_pins(a_pins), .operand_b_in(b_wire),
      .operand_b_out(b_out), .operand_b_oe(b_oe));

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   task automatic check(input fpm_fp8_t seen, input fpm_fp8_t exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Magnitude scaled by 2^10, so every code is a whole number
   function automatic longint val(input fpm_fp8_t x);
      longint s;
      s = (x[6:3] == 4'h0) ? longint'(x[2:0]) : longint'({1'b1, x[2:0]});
      return s << ((x[6:3] == 4'h0) ? 1 : int'(x[6:3]));
   endfunction

   // Largest code not above the exact product; code 0x7F caps overflow
   function automatic fpm_fp8_t ref_mul(input fpm_fp8_t a, input fpm_fp8_t b);
      fpm_fp8_t r;
      r = 8'h00;
      for (int c = 1; c < 128; c++) begin
         if ((val(8'(c)) << 10) <= val(a) * val(b)) r = 8'(c);
      end
      r[7] = a[7] ^ b[7];
      return r;
   endfunction

   task automatic push(input fpm_fp8_t a, input fpm_fp8_t b, input fpm_fp8_t e);
      qa.push_back(a);
      qb.push_back(b);
      qe.push_back(e);
   endtask

   // Back-to-back pairs; each result must land exactly six edges later
   task automatic run_stream();
      int n;
      n = qa.size();
      for (int k = 0; k < n + 6; k++) begin
         fpm_host_model_inst.put(k < n ? qa[k] : 8'h00, k < n ? qb[k] : 8'h00);
         if (k >= 6) check(product, qe[k - 6]);
         check(b_out, 8'h00);
         check({7'h00, b_oe}, 8'h00);
      end
      qa.delete();
      qb.delete();
      qe.delete();
   endtask

   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic sc_signs();
      push(8'h30, 8'h30, 8'h28);
      // Unit pair then unit times two, back to back, for the latency checks
      push(8'h38, 8'h38, 8'h38);
      push(8'h38, 8'h40, 8'h40);
      push(8'h38, 8'hB8, 8'hB8);
      push(8'hB8, 8'hB8, 8'h38);
      push(8'hB0, 8'h38, 8'hB0);
      push(8'h48, 8'h50, 8'h60);
      push(8'h00, 8'h7F, 8'h00);
      run_stream();
   endtask

   task automatic sc_truncate();
      push(8'h39, 8'h39, 8'h3A);
      push(8'h3F, 8'h3F, 8'h46);
      push(8'hB9, 8'h39, 8'hBA);
      run_stream();
   endtask

   task automatic sc_saturate();
      push(8'h7F, 8'h7F, 8'h7F);
      push(8'hFF, 8'h7F, 8'hFF);
      push(8'h77, 8'h40, 8'h7F);
      push(8'h78, 8'h40, 8'h7F);
      push(8'hF8, 8'h40, 8'hFF);
      push(8'h7F, 8'hB8, 8'hFF);
      run_stream();
   endtask

   task automatic sc_subnormal();
      push(8'h01, 8'h40, 8'h02);
      push(8'h01, 8'h30, 8'h00);
      push(8'h81, 8'h30, 8'h80);
      push(8'h08, 8'h30, 8'h04);
      push(8'h07, 8'h48, 8'h16);
      run_stream();
   endtask

   task automatic sc_sweep();
      fpm_fp8_t a;
      fpm_fp8_t b;
      for (int i = 0; i < 256; i++) begin
         a = 8'(i * 37 + 5);
         b = 8'(i * 91 + 3);
         push(a, b, ref_mul(a, b));
      end
      run_stream();
   endtask

   // Reset in mid-run clears every stage; first pair after release lands at six
   task automatic sc_reset_mid();
      for (int k = 0; k < 14; k++) begin
         fpm_host_model_inst.put(8'h38, 8'h48);
         if (k >= 4 && k < 13) check(product, 8'h00);
         if (k == 13) check(product, 8'h48);
         reset_n = (k < 3 || k > 6);
      end
   endtask

   // --------------------------------------------------------------
   // Main sequence and watchdog
   // --------------------------------------------------------------
   initial begin
      n_fail = 0;
      n_checks = 0;
      reset_n = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      check(product, 8'h00);
      reset_n = 1'b1;
      sc_signs();
      sc_truncate();
      sc_saturate();
      sc_subnormal();
      sc_sweep();
      sc_reset_mid();
      close_out();
   end

   initial begin
      #20000;
      n_fail++;
      close_out();
   end
endmodule
